// ### pfs_pkg.sv
package pfs_pkg;
   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0]  CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0]  CMD_SUMMARY_WORD = 8'h79;
   localparam logic [7:0]  CMD_VOUT_FLAGS   = 8'h7A;
   localparam logic [7:0]  CMD_IOUT_FLAGS   = 8'h7B;
   localparam logic [7:0]  CMD_VOUT_MASK    = 8'hD0;
   localparam logic [7:0]  CMD_IOUT_MASK    = 8'hD1;
   localparam logic [7:0]  CMD_BYTE_MASK    = 8'hD2;
   localparam logic [7:0]  CMD_OV_SRC_MASK  = 8'hD3;

   // ------------------------------------------------------------
   // field layouts
   // ------------------------------------------------------------
   localparam logic [7:0]  VOUT_SUPPORTED   = 8'hFC;
   localparam logic [7:0]  IOUT_SUPPORTED   = 8'hB0;
   localparam logic [7:0]  BYTE_BUSY_BIT    = 8'h80;
   localparam logic [2:0]  OV_SRC_ALL       = 3'h7;
   localparam int          BUSY_POS         = 7;
   localparam int          OVF_POS          = 7;
   localparam logic [7:0]  FLAGS_RESET      = 8'h00;
   localparam logic [7:0]  MASK_RESET       = 8'h00;
   localparam logic [15:0] DATA_RESET       = 16'h0000;

   // ------------------------------------------------------------
   // host controller registers (AHB-Lite byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_COMMAND      = 8'h00;
   localparam logic [7:0]  REG_WDATA        = 8'h04;
   localparam logic [7:0]  REG_RDATA        = 8'h08;
   localparam logic [7:0]  REG_STATUS       = 8'h0C;
   localparam int          CMD_WRITE_POS    = 8;
   localparam int          CMD_WORD_POS     = 9;
   localparam int          ST_BUSY_POS      = 0;
   localparam int          ST_DONE_POS      = 1;
   localparam int          ST_NACK_POS      = 2;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ       = 2'h3;

   // latched flag update, a new event wins over a clear
   function automatic logic [7:0] pfs_latch(input logic [7:0] old,
                                            input logic [7:0] set,
                                            input logic [7:0] clr);
      pfs_latch = (old & ~clr) | set;
   endfunction
endpackage

// ### pfs_link_if.sv
interface pfs_link_if;
   logic        req_valid;
   logic        req_ready;
   logic [7:0]  req_cmd;
   logic        req_write;
   logic        req_word;
   logic [15:0] req_wdata;
   logic        rsp_valid;
   logic [15:0] rsp_data;
   logic        rsp_nack;

   modport dev (input  req_valid, req_cmd, req_write, req_word, req_wdata,
                output req_ready, rsp_valid, rsp_data, rsp_nack);
   modport host (output req_valid, req_cmd, req_write, req_word, req_wdata,
                 input  req_ready, rsp_valid, rsp_data, rsp_nack);
endinterface

// ### pfs_device.sv
// What this block does
// - answer 79h with sixteen-bit status word
// - word low byte is the status byte
// - bit 15 is OR of voltage flags
// - bit 14 is OR of current flags
// - bit 13 shows input fault summary
// - bit 12 shows maker fault summary
// - bit 11 is live power good copy
// - bit 9 shows other fault summary
// - bits 10 and 8 read zero
// - word write 0080h clears busy flag
// - word write 0180h clears busy only; unknown flag has no storage
// - each alerting bit has own mask bit
// - voltage byte at 7Ah, write-one or clear-all
// - bit 7 overvoltage, per-source secondary masks
// - bit 6 latches overvoltage warning
// - bit 5 latches undervoltage warning
// - bit 4 latches undervoltage fault
// - bit 3 limit violation, bit 2 startup timeout
// - voltage bits 1:0 read zero
// - current byte at 7Bh, write-one or clear-all
// - current bits 7,5,4 latch; others zero
// - low byte bit 7 is busy flag
module pfs_device (
   input  wire logic  i_ref_clk,
   input  wire logic  i_rstn,
   pfs_link_if.dev    lnk,
   input  wire logic  i_ov_fixed,
   input  wire logic  i_ov_tracking,
   input  wire logic  i_ov_prebias,
   input  wire logic  i_out_overvoltage_warning,
   input  wire logic  i_out_undervoltage_warning,
   input  wire logic  i_out_undervoltage_fault,
   input  wire logic  i_setpoint_limit_violation,
   input  wire logic  i_startup_timeout_flag,
   input  wire logic  i_overcurrent_fault,
   input  wire logic  i_overcurrent_warning,
   input  wire logic  i_undercurrent_fault,
   input  wire logic  i_busy_event,
   input  wire logic  i_power_good_flag,
   input  wire logic  i_not_converting,
   input  wire logic  i_input_fault_summary,
   input  wire logic  i_input_uv_summary,
   input  wire logic  i_temp_summary,
   input  wire logic  i_comm_summary,
   input  wire logic  i_maker_defined_fault_summary,
   input  wire logic  i_other_fault_summary,
   output logic       o_alert
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  vout_flags;
   logic [7:0]  iout_flags;
   logic [2:0]  ov_sources;
   logic        busy;
   logic [7:0]  vout_mask;
   logic [7:0]  iout_mask;
   logic [7:0]  byte_mask;
   logic [2:0]  alert_mask_secondary;

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   logic        take;
   logic        wr;
   logic        clear_all;
   logic        legal;
   logic        is_low_byte_wr;
   logic [7:0]  wbyte;
   logic [7:0]  vout_set;
   logic [7:0]  vout_clr;
   logic [7:0]  iout_set;
   logic [7:0]  iout_clr;
   logic        busy_clr;
   logic [2:0]  ov_src_set;
   logic [7:0]  status_low;
   logic [7:0]  status_high;
   logic [15:0] next_rsp_data;

   assign lnk.req_ready = 1'b1;
   assign take          = lnk.req_valid & lnk.req_ready;
   assign wr            = take & lnk.req_write;
   assign wbyte         = lnk.req_wdata[7:0];
   assign clear_all     = wr & (lnk.req_cmd == pfs_pkg::CMD_CLEAR_FAULTS);

   always_comb begin
      case (lnk.req_cmd)
         pfs_pkg::CMD_CLEAR_FAULTS: legal = lnk.req_write;
         pfs_pkg::CMD_SUMMARY_WORD: legal = lnk.req_word;
         pfs_pkg::CMD_STATUS_BYTE,
         pfs_pkg::CMD_VOUT_FLAGS,
         pfs_pkg::CMD_IOUT_FLAGS,
         pfs_pkg::CMD_VOUT_MASK,
         pfs_pkg::CMD_IOUT_MASK,
         pfs_pkg::CMD_BYTE_MASK,
         pfs_pkg::CMD_OV_SRC_MASK:  legal = ~lnk.req_word;
         default:                   legal = 1'b0;
      endcase
   end

   // both views write the same busy storage
   assign is_low_byte_wr = wr & legal & ((lnk.req_cmd == pfs_pkg::CMD_SUMMARY_WORD)
                         | (lnk.req_cmd == pfs_pkg::CMD_STATUS_BYTE));
   // 0080h and 0180h both carry bit 7; unknown flag has no storage
   assign busy_clr  = clear_all | (is_low_byte_wr & wbyte[pfs_pkg::BUSY_POS]);

   assign ov_src_set = {i_ov_prebias, i_ov_tracking, i_ov_fixed};
   assign vout_set   = {|ov_src_set, i_out_overvoltage_warning,
                        i_out_undervoltage_warning, i_out_undervoltage_fault,
                        i_setpoint_limit_violation, i_startup_timeout_flag,
                        2'b00};
   assign iout_set   = {i_overcurrent_fault, 1'b0, i_overcurrent_warning,
                        i_undercurrent_fault, 4'h0};
   assign vout_clr   = clear_all ? pfs_pkg::VOUT_SUPPORTED :
                       ((wr & legal & (lnk.req_cmd == pfs_pkg::CMD_VOUT_FLAGS))
                       ? (wbyte & pfs_pkg::VOUT_SUPPORTED) : pfs_pkg::FLAGS_RESET);
   assign iout_clr   = clear_all ? pfs_pkg::IOUT_SUPPORTED :
                       ((wr & legal & (lnk.req_cmd == pfs_pkg::CMD_IOUT_FLAGS))
                       ? (wbyte & pfs_pkg::IOUT_SUPPORTED) : pfs_pkg::FLAGS_RESET);

   // ------------------------------------------------------------
   // latched flags
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         vout_flags <= pfs_pkg::FLAGS_RESET;
         iout_flags <= pfs_pkg::FLAGS_RESET;
      end else begin
         vout_flags <= pfs_pkg::pfs_latch(vout_flags, vout_set, vout_clr);
         iout_flags <= pfs_pkg::pfs_latch(iout_flags, iout_set, iout_clr);
      end
   end

   // overvoltage source record, cleared with its flag
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ov_sources <= '0;
      end else if (vout_clr[pfs_pkg::OVF_POS]) begin
         ov_sources <= ov_src_set;
      end else begin
         ov_sources <= ov_sources | ov_src_set;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy <= 1'b0;
      end else begin
         busy <= i_busy_event | (busy & ~busy_clr);
      end
   end

   // ------------------------------------------------------------
   // alert masks
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         vout_mask            <= pfs_pkg::MASK_RESET;
         iout_mask            <= pfs_pkg::MASK_RESET;
         byte_mask            <= pfs_pkg::MASK_RESET;
         alert_mask_secondary <= '0;
      end else if (wr & legal) begin
         case (lnk.req_cmd)
            pfs_pkg::CMD_VOUT_MASK:   vout_mask <= wbyte & pfs_pkg::VOUT_SUPPORTED;
            pfs_pkg::CMD_IOUT_MASK:   iout_mask <= wbyte & pfs_pkg::IOUT_SUPPORTED;
            pfs_pkg::CMD_BYTE_MASK:   byte_mask <= wbyte & pfs_pkg::BYTE_BUSY_BIT;
            pfs_pkg::CMD_OV_SRC_MASK: alert_mask_secondary <= wbyte[2:0];
            default:                  ;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_alert <= 1'b0;
      end else begin
         o_alert <= (|(vout_flags & ~vout_mask & ~pfs_pkg::BYTE_BUSY_BIT))
                  | (vout_flags[pfs_pkg::OVF_POS] & ~vout_mask[pfs_pkg::OVF_POS]
                     & |(ov_sources & ~alert_mask_secondary))
                  | (|(iout_flags & ~iout_mask))
                  | (busy & ~byte_mask[pfs_pkg::BUSY_POS]);
      end
   end

   // ------------------------------------------------------------
   // read views and answer
   // ------------------------------------------------------------
   assign status_low  = {busy, i_not_converting, vout_flags[pfs_pkg::OVF_POS],
                         iout_flags[pfs_pkg::OVF_POS], i_input_uv_summary,
                         i_temp_summary, i_comm_summary, i_other_fault_summary};
   assign status_high = {|vout_flags, |iout_flags,
                         i_input_fault_summary, i_maker_defined_fault_summary,
                         i_power_good_flag, 1'b0,
                         i_other_fault_summary, 1'b0};

   always_comb begin
      case (lnk.req_cmd)
         pfs_pkg::CMD_SUMMARY_WORD: next_rsp_data = {status_high, status_low};
         pfs_pkg::CMD_STATUS_BYTE:  next_rsp_data = {8'h00, status_low};
         pfs_pkg::CMD_VOUT_FLAGS:   next_rsp_data = {8'h00, vout_flags};
         pfs_pkg::CMD_IOUT_FLAGS:   next_rsp_data = {8'h00, iout_flags};
         pfs_pkg::CMD_VOUT_MASK:    next_rsp_data = {8'h00, vout_mask};
         pfs_pkg::CMD_IOUT_MASK:    next_rsp_data = {8'h00, iout_mask};
         pfs_pkg::CMD_BYTE_MASK:    next_rsp_data = {8'h00, byte_mask};
         pfs_pkg::CMD_OV_SRC_MASK:  next_rsp_data = {13'h0000, alert_mask_secondary};
         default:                   next_rsp_data = pfs_pkg::DATA_RESET;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lnk.rsp_valid <= 1'b0;
         lnk.rsp_data  <= pfs_pkg::DATA_RESET;
         lnk.rsp_nack  <= 1'b0;
      end else begin
         lnk.rsp_valid <= take;
         if (take) begin
            lnk.rsp_data <= (legal & ~lnk.req_write) ? next_rsp_data : pfs_pkg::DATA_RESET;
            lnk.rsp_nack <= ~legal;
         end
      end
   end
endmodule

// ### pfs_host.sv
module pfs_host (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   pfs_link_if.host         lnk,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata
);
   typedef enum logic [1:0] {PFS_IDLE, PFS_REQ, PFS_WAIT} pfs_state_t;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   pfs_state_t  state;
   logic        dp_write;
   logic [7:0]  dp_addr;
   logic        addr_ok;
   logic        start;
   logic [9:0]  command;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        done;
   logic        nack;

   assign addr_ok     = i_hsel & i_hready & (i_htrans == pfs_pkg::HTRANS_NONSEQ
                        | i_htrans == pfs_pkg::HTRANS_SEQ);
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign start       = dp_write & (dp_addr == pfs_pkg::REG_COMMAND) & (state == PFS_IDLE);

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dp_write <= 1'b0;
         dp_addr  <= '0;
      end else begin
         dp_write <= addr_ok & i_hwrite;
         dp_addr  <= i_haddr[7:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_hrdata <= '0;
      end else if (addr_ok & ~i_hwrite) begin
         case (i_haddr[7:0])
            pfs_pkg::REG_COMMAND: o_hrdata <= {22'h000000, command};
            pfs_pkg::REG_WDATA:   o_hrdata <= {16'h0000, wdata};
            pfs_pkg::REG_RDATA:   o_hrdata <= {16'h0000, rdata};
            pfs_pkg::REG_STATUS:  o_hrdata <= {29'h00000000, nack, done, state != PFS_IDLE};
            default:              o_hrdata <= '0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         command <= '0;
         wdata   <= pfs_pkg::DATA_RESET;
      end else begin
         if (start) begin
            command <= i_hwdata[9:0];
         end
         if (dp_write & (dp_addr == pfs_pkg::REG_WDATA) & (state == PFS_IDLE)) begin
            wdata <= i_hwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // link master
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state         <= PFS_IDLE;
         lnk.req_valid <= 1'b0;
         lnk.req_cmd   <= '0;
         lnk.req_write <= 1'b0;
         lnk.req_word  <= 1'b0;
         lnk.req_wdata <= pfs_pkg::DATA_RESET;
      end else begin
         case (state)
            PFS_IDLE: begin
               if (start) begin
                  state         <= PFS_REQ;
                  lnk.req_valid <= 1'b1;
                  lnk.req_cmd   <= i_hwdata[7:0];
                  lnk.req_write <= i_hwdata[pfs_pkg::CMD_WRITE_POS];
                  lnk.req_word  <= i_hwdata[pfs_pkg::CMD_WORD_POS];
                  lnk.req_wdata <= wdata;
               end
            end
            PFS_REQ: begin
               if (lnk.req_ready) begin
                  state         <= PFS_WAIT;
                  lnk.req_valid <= 1'b0;
               end
            end
            PFS_WAIT: begin
               if (lnk.rsp_valid) begin
                  state <= PFS_IDLE;
               end
            end
            default: state <= PFS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata <= pfs_pkg::DATA_RESET;
         done  <= 1'b0;
         nack  <= 1'b0;
      end else if (start) begin
         done <= 1'b0;
         nack <= 1'b0;
      end else if ((state == PFS_WAIT) & lnk.rsp_valid) begin
         rdata <= lnk.rsp_data;
         done  <= 1'b1;
         nack  <= lnk.rsp_nack;
      end
   end
endmodule

// ### pfs_link_asserts.sv
module pfs_link_asserts (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   input  wire logic        req_valid,
   input  wire logic        req_ready,
   input  wire logic [7:0]  req_cmd,
   input  wire logic        req_write,
   input  wire logic        req_word,
   input  wire logic [15:0] req_wdata,
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   input  wire logic        rsp_nack
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic rd  = req_valid && !req_write;
   wire logic brd = rd && !req_word;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rstn);
   // ------------------------------------------------------------
   // link handshake
   // ------------------------------------------------------------
   ready_const_a: assert property (req_ready)
      else $error("link ready dropped");
   answer_next_a: assert property (req_valid |=> rsp_valid)
      else $error("no answer one cycle after request");
   answer_cause_a: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer without request");
   answer_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   answer_hold_a: assert property (!rsp_valid |-> $stable(rsp_data) && $stable(rsp_nack))
      else $error("answer data moved between answers");
   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   word_read_a: assert property (rd && req_word && req_cmd == pfs_pkg::CMD_SUMMARY_WORD
      |=> !rsp_nack && rsp_data[10] == 1'b0 && rsp_data[8] == 1'b0)
      else $error("word read refused or bits 10 8 set");
   word_width_a: assert property (req_valid && !req_word
      && req_cmd == pfs_pkg::CMD_SUMMARY_WORD |=> rsp_nack && rsp_data == 16'h0000)
      else $error("byte access to word accepted");
   flag_width_a: assert property (req_valid && req_word && (req_cmd == pfs_pkg::CMD_VOUT_FLAGS
      || req_cmd == pfs_pkg::CMD_IOUT_FLAGS) |=> rsp_nack)
      else $error("word access to flag byte accepted");
   vout_zero_a: assert property (brd && req_cmd == pfs_pkg::CMD_VOUT_FLAGS
      |=> !rsp_nack && rsp_data[1:0] == 2'h0 && rsp_data[15:8] == 8'h00)
      else $error("voltage unsupported bits set");
   iout_zero_a: assert property (brd && req_cmd == pfs_pkg::CMD_IOUT_FLAGS
      |=> !rsp_nack && (rsp_data & 16'hFF4F) == 16'h0000)
      else $error("current unsupported bits set");
   write_data_a: assert property (req_valid && req_write |=> rsp_data == 16'h0000)
      else $error("write answer carries data");
   clear_read_a: assert property (rd && req_cmd == pfs_pkg::CMD_CLEAR_FAULTS |=> rsp_nack)
      else $error("read of clear-all accepted");
   busy_clear_a: assert property (req_valid && req_write && req_word
      && req_cmd == pfs_pkg::CMD_SUMMARY_WORD && req_wdata[7] |=> !rsp_nack)
      else $error("status word clear write refused");
   cover property (rd && req_word && req_cmd == pfs_pkg::CMD_SUMMARY_WORD);
   cover property (req_valid && req_write && req_cmd == pfs_pkg::CMD_VOUT_FLAGS);
   cover property (rsp_valid && rsp_nack);
   cover property (req_valid && req_write && req_cmd == pfs_pkg::CMD_OV_SRC_MASK);
endmodule

// ### pmbus_fault_status_word_tb.sv
module pmbus_fault_status_word_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk = 1'b0;
   logic        i_rstn    = 1'b0;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [2:0]  hsize     = 3'h2;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [11:0] ev        = 12'h000;
   logic [7:0]  lv        = 8'h00;
   logic [7:0]  m_vout;
   logic [7:0]  m_iout;
   logic        m_busy;
   wire logic   hready;
   wire logic   hresp;
   wire logic   alert;
   wire logic [31:0] hrdata;
   int          err_count  = 0;
   int          num_checks = 0;
   pfs_link_if pfs_link_if_i ();
   pfs_device pfs_device_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .lnk(pfs_link_if_i),
      .i_ov_fixed(ev[0]), .i_ov_tracking(ev[1]), .i_ov_prebias(ev[2]),
      .i_out_overvoltage_warning(ev[3]), .i_out_undervoltage_warning(ev[4]),
      .i_out_undervoltage_fault(ev[5]), .i_setpoint_limit_violation(ev[6]),
      .i_startup_timeout_flag(ev[7]), .i_overcurrent_fault(ev[8]),
      .i_overcurrent_warning(ev[9]), .i_undercurrent_fault(ev[10]), .i_busy_event(ev[11]),
      .i_power_good_flag(lv[0]), .i_not_converting(lv[1]), .i_input_fault_summary(lv[2]),
      .i_input_uv_summary(lv[3]), .i_temp_summary(lv[4]), .i_comm_summary(lv[5]),
      .i_maker_defined_fault_summary(lv[6]), .i_other_fault_summary(lv[7]), .o_alert(alert));
   pfs_host pfs_host_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .lnk(pfs_link_if_i),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
      .o_hrdata(hrdata));
   pfs_link_asserts pfs_link_asserts_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .req_valid(pfs_link_if_i.req_valid), .req_ready(pfs_link_if_i.req_ready),
      .req_cmd(pfs_link_if_i.req_cmd), .req_write(pfs_link_if_i.req_write),
      .req_word(pfs_link_if_i.req_word), .req_wdata(pfs_link_if_i.req_wdata),
      .rsp_valid(pfs_link_if_i.rsp_valid), .rsp_data(pfs_link_if_i.rsp_data),
      .rsp_nack(pfs_link_if_i.rsp_nack));
   initial begin
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         err_count++;
         wrap_up();
      end
   endtask
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
      @(posedge i_ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= pfs_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      chk("hresp", hresp, 0);
   endtask
   // one device transaction through the controller registers
   task automatic pm(logic w, logic wd, logic [7:0] c, logic [15:0] d,
                     output logic [15:0] r, output logic nk);
      logic [31:0] t;
      int n;
      ahb(1'b1, pfs_pkg::REG_WDATA, {16'h0, d}, t);
      ahb(1'b1, pfs_pkg::REG_COMMAND, {22'h0, wd, w, c}, t);
      n = 0;
      do begin
         ahb(1'b0, pfs_pkg::REG_STATUS, 32'h0, t);
         n++;
      end while (t[pfs_pkg::ST_DONE_POS] !== 1'b1 && n < 20);
      if (t[pfs_pkg::ST_DONE_POS] !== 1'b1) begin
         err_count++;
         wrap_up();
      end
      nk = t[pfs_pkg::ST_NACK_POS];
      ahb(1'b0, pfs_pkg::REG_RDATA, 32'h0, t);
      r = t[15:0];
      if (w && nk === 1'b0) begin
         case (c)
            pfs_pkg::CMD_VOUT_FLAGS: m_vout &= ~(d[7:0] & pfs_pkg::VOUT_SUPPORTED);
            pfs_pkg::CMD_IOUT_FLAGS: m_iout &= ~(d[7:0] & pfs_pkg::IOUT_SUPPORTED);
            pfs_pkg::CMD_STATUS_BYTE, pfs_pkg::CMD_SUMMARY_WORD: if (d[7]) m_busy = 1'b0;
            pfs_pkg::CMD_CLEAR_FAULTS: {m_vout, m_iout, m_busy} = 17'h0;
            default: ;
         endcase
      end
   endtask
   task automatic pulse(int k);
      @(posedge i_ref_clk);
      ev[k] <= 1'b1;
      @(posedge i_ref_clk);
      ev[k] <= 1'b0;
      if (k < 3) m_vout[7] = 1'b1;
      else if (k < 8) m_vout[9-k] = 1'b1;
      else if (k == 8) m_iout[7] = 1'b1;
      else if (k < 11) m_iout[14-k] = 1'b1;
      else m_busy = 1'b1;
   endtask
   function automatic logic [15:0] ew();
      ew = {|m_vout, |m_iout, lv[2], lv[6], lv[0], 1'b0, lv[7], 1'b0,
            m_busy, lv[1], m_vout[7], m_iout[7], lv[3], lv[4], lv[5], lv[7]};
   endfunction
   task automatic check_all();
      logic [15:0] r;
      logic nk;
      pm(1'b0, 1'b1, pfs_pkg::CMD_SUMMARY_WORD, 16'h0, r, nk);
      chk("word", {nk, r}, {1'b0, ew()});
      pm(1'b0, 1'b0, pfs_pkg::CMD_STATUS_BYTE, 16'h0, r, nk);
      chk("byte", {nk, r}, {9'h0, 8'(ew())});
      pm(1'b0, 1'b0, pfs_pkg::CMD_VOUT_FLAGS, 16'h0, r, nk);
      chk("vout", {nk, r}, {9'h0, m_vout});
      pm(1'b0, 1'b0, pfs_pkg::CMD_IOUT_FLAGS, 16'h0, r, nk);
      chk("iout", {nk, r}, {9'h0, m_iout});
      chk("alert", alert, |{m_vout, m_iout, m_busy});
   endtask
   task automatic do_reset();
      i_rstn <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      {m_vout, m_iout, m_busy} = 17'h0;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   logic [9:0]  bad [6] = '{10'h079, 10'h27A, 10'h27B, 10'h003, 10'h278, 10'h179};
   logic [19:0] mc  [6] = '{20'h3D040, 20'h8D180, 20'hBD280, 20'h0D301, 20'h1D302, 20'h2D304};
   initial begin
      logic [31:0] t;
      logic [15:0] r;
      logic nk;
      void'($urandom(89365));
      do_reset();
      check_all();
      ahb(1'b0, 8'h10, 32'h0, t);
      chk("unmapped", t, 32'h0);
      $display("test reset done");
      repeat (16) begin
         pulse($urandom_range(11, 0));
         lv <= 8'($urandom);
         check_all();
         case ($urandom_range(3, 0))
            0: pm(1'b1, 1'b0, pfs_pkg::CMD_VOUT_FLAGS, 16'($urandom), r, nk);
            1: pm(1'b1, 1'b0, pfs_pkg::CMD_IOUT_FLAGS, 16'($urandom), r, nk);
            2: pm(1'b1, 1'b1, pfs_pkg::CMD_SUMMARY_WORD, $urandom_range(1, 0) ? 16'h0180 : 16'h0080, r, nk);
            default: pm(1'b1, 1'b0, pfs_pkg::CMD_STATUS_BYTE, 16'h0080, r, nk);
         endcase
         chk("write nack", nk, 0);
      end
      check_all();
      $display("test random done");
      for (int i = 0; i < 6; i++) begin
         pm(bad[i][8], bad[i][9], bad[i][7:0], 16'h0180, r, nk);
         chk("refused", {nk, r}, 17'h10000);
      end
      check_all();
      $display("test refusal done");
      for (int k = 0; k < 12; k += 4) pulse(k);
      pm(1'b1, 1'b0, pfs_pkg::CMD_CLEAR_FAULTS, 16'h0, r, nk);
      check_all();
      $display("test clear all done");
      for (int i = 0; i < 6; i++) begin
         pm(1'b1, 1'b0, pfs_pkg::CMD_CLEAR_FAULTS, 16'h0, r, nk);
         pulse(mc[i][19:16]);
         pm(1'b1, 1'b0, mc[i][15:8], {8'h0, mc[i][7:0]}, r, nk);
         chk("masked alert", alert, 0);
         pm(1'b0, 1'b0, mc[i][15:8], 16'h0, r, nk);
         chk("mask readback", {nk, r}, {9'h0, mc[i][7:0]});
         pm(1'b1, 1'b0, mc[i][15:8], 16'h0, r, nk);
         chk("unmasked alert", alert, 1);
      end
      $display("test masks done");
      pulse(5);
      do_reset();
      check_all();
      $display("test second reset done");
      wrap_up();
   end
endmodule
